// ===== ppf_pkg.sv
// package for the port pin function block: register map, reset values, field positions, carrier types
// assumes a single 10 MHz bus clock and an AHB-Lite master with whole-word single transfers
package ppf_pkg;

  // clock rate of hclk
  localparam int unsigned CLK_HZ        = 10_000_000;

  // port slots inside the block
  localparam int unsigned NPORT         = 6;
  localparam int unsigned PORT_GEN      = 0;
  localparam int unsigned PORT_ANALOG   = 1;
  localparam int unsigned PORT_TIMER    = 2;
  localparam int unsigned PORT_SEG_A    = 3;
  localparam int unsigned PORT_SEG_B    = 4;
  localparam int unsigned PORT_EDGE     = 5;

  // word index = haddr[6:2]; each port owns four words starting at port*4
  localparam logic [1:0] SEL_DATA       = 2'h0;
  localparam logic [1:0] SEL_MODE       = 2'h1;
  localparam logic [1:0] SEL_PULL       = 2'h2;
  localparam logic [4:0] IDX_PORT_END   = 5'h18;
  localparam logic [4:0] IDX_LCD_CTRL   = 5'h18;
  localparam logic [4:0] IDX_CLK_CTRL   = 5'h19;
  localparam logic [4:0] IDX_RISE_SEL   = 5'h1a;
  localparam logic [4:0] IDX_FALL_SEL   = 5'h1b;
  localparam logic [4:0] IDX_IRQ_STAT   = 5'h1c;
  localparam logic [4:0] IDX_IRQ_MASK   = 5'h1d;
  localparam logic [4:0] IDX_ALT_SEL    = 5'h1e;
  localparam logic [4:0] IDX_ADC_SEL    = 5'h1f;

  // reset values
  localparam logic [7:0]  MODE_RST      = 8'hff;
  localparam logic [7:0]  PULL_RST      = 8'h00;
  localparam logic [7:0]  LATCH_RST     = 8'h00;
  localparam logic [7:0]  CTRL_RST      = 8'h00;
  localparam logic [15:0] STAT_RST      = 16'h0000;

  // port 0 bits that are input only (bit 0, the unbonded bit 6, and the subclock shared bit 7)
  localparam logic [7:0]  GEN_IN_ONLY   = 8'hc1;
  localparam int unsigned SUBCLK_BIT    = 7;

  // field positions
  localparam int unsigned FB_CUT_BIT    = 6;
  localparam int unsigned ALT_TIMER_BIT = 0;
  localparam int unsigned NEXT_INT      = 6;
  localparam int unsigned STAT_EXT_LSB  = 0;
  localparam int unsigned STAT_EDGE_LSB = 8;
  localparam int unsigned NSEG_GROUP    = 4;

  // AHB encodings
  localparam logic [1:0]  HTRANS_NONSEQ = 2'b10;
  localparam logic        HRESP_OKAY    = 1'b0;

  typedef struct packed {
    logic [7:0] dout;
    logic [7:0] oe;
    logic [7:0] pu;
  } ppf_pin_group_type;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [4:0] idx;
  } ppf_req_type;

endpackage : ppf_pkg

// ===== ppf_pio.sv
// one eight-bit bidirectional port: pin synchroniser, direction, pull-up and alternate output mux
// assumes mode bit 1 means input; alt_en takes the pin over as an output
`timescale 1ns/1ps
module ppf_pio
(
  input  wire logic                       hclk,
  input  wire logic                       hresetn,
  input  wire logic [7:0]                 pin_in,
  input  wire logic [7:0]                 mode,
  input  wire logic [7:0]                 latch,
  input  wire logic [7:0]                 pu_en,
  input  wire logic [7:0]                 pu_block,
  input  wire logic [7:0]                 alt_en,
  input  wire logic [7:0]                 alt_data,
  output ppf_pkg::ppf_pin_group_type      pins,
  output logic      [7:0]                 level
);

  logic [7:0] meta_ff;
  logic [7:0] level_ff;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      meta_ff  <= 8'h00;
      level_ff <= 8'h00;
    end
    else
    begin
      meta_ff  <= pin_in;
      level_ff <= meta_ff;
    end
  end

  assign level     = level_ff;
  assign pins.oe   = alt_en | ~mode;
  assign pins.dout = (alt_en & alt_data) | (~alt_en & latch);
  assign pins.pu   = pu_en & mode & ~alt_en & ~pu_block;

endmodule : ppf_pio

// ===== ppf_edge.sv
// edge finder on already synchronised levels, with per-bit rising and falling enables
// assumes the level inputs come from flip-flops on hclk
`timescale 1ns/1ps
module ppf_edge
#(
  parameter int unsigned W = 8
)
(
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic [W-1:0] level,
  input  wire logic [W-1:0] rise_en,
  input  wire logic [W-1:0] fall_en,
  output logic      [W-1:0] hit
);

  logic [W-1:0] prev_ff;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      prev_ff <= '0;
    else
      prev_ff <= level;
  end

  assign hit = (rise_en & level & ~prev_ff) | (fall_en & ~level & prev_ff);

endmodule : ppf_edge

// ===== ppf_port_ctrl.sv
// port pin function control: six ports, lcd segment sharing, analog sharing, timer output, pin interrupts
// assumes an AHB-Lite master with single word transfers; hready is the one slave's hreadyout
//
// How it works
// - every port bit has its own direction, except port 0 bits 0, 6 and 7, which are input only
// - input bits may switch on software pull-up
// - lcd control picks segment or port per pin pair
// - edge port flags falling edges on pins
// - six external interrupts choose rising, falling, both
// - analog pins input mode, pull-ups auto disabled
// - first timer pin carries the wide timer output
`timescale 1ns/1ps
module ppf_port_ctrl
(
  input  wire logic                                   hclk,
  input  wire logic                                   hresetn,
  input  wire logic                                   hsel,
  input  wire logic [31:0]                            haddr,
  input  wire logic [1:0]                             htrans,
  input  wire logic                                   hwrite,
  input  wire logic [2:0]                             hsize,
  input  wire logic [31:0]                            hwdata,
  input  wire logic                                   hready,
  output logic      [31:0]                            hrdata,
  output logic                                        hreadyout,
  output logic                                        hresp,
  input  wire logic [ppf_pkg::NPORT-1:0][7:0]         pin_in,
  output ppf_pkg::ppf_pin_group_type [ppf_pkg::NPORT-1:0] pins,
  input  wire logic [15:0]                            shared_segment_outputs,
  input  wire logic                                   wide_timer_out,
  output logic      [7:0]                             converter_input_sel,
  output logic                                        feedback_resistor_cut_bit,
  output logic      [ppf_pkg::NEXT_INT-1:0]           ext_int_req,
  output logic                                        irq
);

  ppf_pkg::ppf_req_type a_ff;
  ppf_pkg::ppf_req_type nxt_a;
  logic                 rd_done_ff;
  logic [31:0]          hrdata_ff;
  logic [31:0]          rdata;

  logic [ppf_pkg::NPORT-1:0][7:0] mode_ff;
  logic [ppf_pkg::NPORT-1:0][7:0] latch_ff;
  logic [ppf_pkg::NPORT-1:0][7:0] pull_ff;
  logic [ppf_pkg::NPORT-1:0][7:0] mode_eff;
  logic [ppf_pkg::NPORT-1:0][7:0] level;
  logic [ppf_pkg::NPORT-1:0][7:0] alt_en;
  logic [ppf_pkg::NPORT-1:0][7:0] alt_data;
  logic [ppf_pkg::NPORT-1:0][7:0] pu_block;
  logic [ppf_pkg::NPORT-1:0][7:0] port_view;

  logic [7:0]  lcd_display_control_reg_ff;
  logic [7:0]  processor_clock_control_reg_ff;
  logic [7:0]  rise_sel_ff;
  logic [7:0]  fall_sel_ff;
  logic [7:0]  alt_sel_ff;
  logic [7:0]  adc_sel_ff;
  logic [15:0] irq_stat_ff;
  logic [15:0] irq_mask_ff;
  logic [15:0] nxt_irq_stat;

  // bus decode
  wire        accept    = hsel & hready & (htrans == ppf_pkg::HTRANS_NONSEQ);
  wire        rd_cap    = a_ff.rd & ~rd_done_ff;
  wire        wr_fire   = a_ff.wr;
  wire [2:0]  d_port    = a_ff.idx[4:2];
  wire [1:0]  d_sel     = a_ff.idx[1:0];
  wire        d_is_port = a_ff.idx < ppf_pkg::IDX_PORT_END;
  wire [7:0]  wbyte     = hwdata[7:0];

  assign nxt_a.wr  = accept & hwrite;
  assign nxt_a.rd  = accept & ~hwrite;
  assign nxt_a.idx = haddr[6:2];

  // reads take one wait cycle so that read data always leaves a flip-flop
  assign hreadyout = ~rd_cap;
  assign hresp     = ppf_pkg::HRESP_OKAY;
  assign hrdata    = hrdata_ff;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      a_ff       <= '0;
      rd_done_ff <= 1'b0;
      hrdata_ff  <= 32'h0000_0000;
    end
    else
    begin
      rd_done_ff <= rd_cap;
      if (rd_cap)
        hrdata_ff <= rdata;
      if (hready)
        a_ff <= nxt_a;
    end
  end

  // per-port registers and pin logic
  genvar gp;
  generate
    for (gp = 0; gp < ppf_pkg::NPORT; gp++)
    begin : g_port
      wire hit_port = wr_fire & d_is_port & (d_port == 3'(gp));

      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          mode_ff[gp]  <= ppf_pkg::MODE_RST;
          latch_ff[gp] <= ppf_pkg::LATCH_RST;
          pull_ff[gp]  <= ppf_pkg::PULL_RST;
        end
        else
        begin
          if (hit_port && d_sel == ppf_pkg::SEL_MODE)
            mode_ff[gp] <= wbyte;
          if (hit_port && d_sel == ppf_pkg::SEL_DATA)
            latch_ff[gp] <= wbyte;
          if (hit_port && d_sel == ppf_pkg::SEL_PULL)
            pull_ff[gp] <= wbyte;
        end
      end

      // a pin in output mode reads back its latch, in input mode its level
      assign port_view[gp] = (latch_ff[gp] & ~mode_eff[gp]) | (level[gp] & mode_eff[gp]);

      ppf_pio u_pio
      (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .pin_in   (pin_in[gp]),
        .mode     (mode_eff[gp]),
        .latch    (latch_ff[gp]),
        .pu_en    (pull_ff[gp]),
        .pu_block (pu_block[gp]),
        .alt_en   (alt_en[gp]),
        .alt_data (alt_data[gp]),
        .pins     (pins[gp]),
        .level    (level[gp])
      );
    end
  endgenerate

  // input-only bits of port 0 never drive and never pull
  assign mode_eff[ppf_pkg::PORT_GEN]    = mode_ff[ppf_pkg::PORT_GEN] | ppf_pkg::GEN_IN_ONLY;
  assign mode_eff[ppf_pkg::PORT_ANALOG] = mode_ff[ppf_pkg::PORT_ANALOG];
  assign mode_eff[ppf_pkg::PORT_TIMER]  = mode_ff[ppf_pkg::PORT_TIMER];
  assign mode_eff[ppf_pkg::PORT_SEG_A]  = mode_ff[ppf_pkg::PORT_SEG_A];
  assign mode_eff[ppf_pkg::PORT_SEG_B]  = mode_ff[ppf_pkg::PORT_SEG_B];
  assign mode_eff[ppf_pkg::PORT_EDGE]   = mode_ff[ppf_pkg::PORT_EDGE];

  assign pu_block[ppf_pkg::PORT_GEN]    = ppf_pkg::GEN_IN_ONLY;
  assign pu_block[ppf_pkg::PORT_ANALOG] = adc_sel_ff;
  assign pu_block[ppf_pkg::PORT_TIMER]  = 8'h00;
  assign pu_block[ppf_pkg::PORT_SEG_A]  = 8'h00;
  assign pu_block[ppf_pkg::PORT_SEG_B]  = 8'h00;
  assign pu_block[ppf_pkg::PORT_EDGE]   = 8'h00;

  // segment sharing in pairs of pins
  logic [7:0] seg_en_a;
  logic [7:0] seg_en_b;
  genvar gg;
  generate
    for (gg = 0; gg < ppf_pkg::NSEG_GROUP; gg++)
    begin : g_seg
      assign seg_en_a[2*gg +: 2] = {2{lcd_display_control_reg_ff[gg]}};
      assign seg_en_b[2*gg +: 2] = {2{lcd_display_control_reg_ff[gg + ppf_pkg::NSEG_GROUP]}};
    end
  endgenerate

  assign alt_en[ppf_pkg::PORT_GEN]      = 8'h00;
  assign alt_en[ppf_pkg::PORT_ANALOG]   = 8'h00;
  assign alt_en[ppf_pkg::PORT_TIMER]    = {7'h00, alt_sel_ff[ppf_pkg::ALT_TIMER_BIT]};
  assign alt_en[ppf_pkg::PORT_SEG_A]    = seg_en_a;
  assign alt_en[ppf_pkg::PORT_SEG_B]    = seg_en_b;
  assign alt_en[ppf_pkg::PORT_EDGE]     = 8'h00;
  assign alt_data[ppf_pkg::PORT_GEN]    = 8'h00;
  assign alt_data[ppf_pkg::PORT_ANALOG] = 8'h00;
  assign alt_data[ppf_pkg::PORT_TIMER]  = {7'h00, wide_timer_out};
  assign alt_data[ppf_pkg::PORT_SEG_A]  = shared_segment_outputs[7:0];
  assign alt_data[ppf_pkg::PORT_SEG_B]  = shared_segment_outputs[15:8];
  assign alt_data[ppf_pkg::PORT_EDGE]   = 8'h00;

  // analog selection only takes a pin whose direction is input
  assign converter_input_sel        = adc_sel_ff & mode_ff[ppf_pkg::PORT_ANALOG];
  assign feedback_resistor_cut_bit  = processor_clock_control_reg_ff[ppf_pkg::FB_CUT_BIT];

  // control registers
  wire wr_lcd  = wr_fire & (a_ff.idx == ppf_pkg::IDX_LCD_CTRL);
  wire wr_clk  = wr_fire & (a_ff.idx == ppf_pkg::IDX_CLK_CTRL);
  wire wr_rise = wr_fire & (a_ff.idx == ppf_pkg::IDX_RISE_SEL);
  wire wr_fall = wr_fire & (a_ff.idx == ppf_pkg::IDX_FALL_SEL);
  wire wr_mask = wr_fire & (a_ff.idx == ppf_pkg::IDX_IRQ_MASK);
  wire wr_alt  = wr_fire & (a_ff.idx == ppf_pkg::IDX_ALT_SEL);
  wire wr_adc  = wr_fire & (a_ff.idx == ppf_pkg::IDX_ADC_SEL);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      lcd_display_control_reg_ff     <= ppf_pkg::CTRL_RST;
      processor_clock_control_reg_ff <= ppf_pkg::CTRL_RST;
      rise_sel_ff                    <= ppf_pkg::CTRL_RST;
      fall_sel_ff                    <= ppf_pkg::CTRL_RST;
      alt_sel_ff                     <= ppf_pkg::CTRL_RST;
      adc_sel_ff                     <= ppf_pkg::CTRL_RST;
      irq_mask_ff                    <= ppf_pkg::STAT_RST;
    end
    else
    begin
      if (wr_lcd)
        lcd_display_control_reg_ff <= wbyte;
      if (wr_clk)
        processor_clock_control_reg_ff <= wbyte;
      if (wr_rise)
        rise_sel_ff <= wbyte;
      if (wr_fall)
        fall_sel_ff <= wbyte;
      if (wr_alt)
        alt_sel_ff <= wbyte;
      if (wr_adc)
        adc_sel_ff <= wbyte;
      if (wr_mask)
        irq_mask_ff <= hwdata[15:0];
    end
  end

  // edge detection on external interrupt pins and on the edge port
  logic [ppf_pkg::NEXT_INT-1:0] ext_hit;
  logic [7:0]                   edge_hit;

  ppf_edge #(.W(ppf_pkg::NEXT_INT)) u_ext_edge
  (
    .hclk    (hclk),
    .hresetn (hresetn),
    .level   (level[ppf_pkg::PORT_GEN][ppf_pkg::NEXT_INT-1:0]),
    .rise_en (rise_sel_ff[ppf_pkg::NEXT_INT-1:0]),
    .fall_en (fall_sel_ff[ppf_pkg::NEXT_INT-1:0]),
    .hit     (ext_hit)
  );

  ppf_edge #(.W(8)) u_fall_edge
  (
    .hclk    (hclk),
    .hresetn (hresetn),
    .level   (level[ppf_pkg::PORT_EDGE]),
    .rise_en (8'h00),
    .fall_en (8'hff),
    .hit     (edge_hit)
  );

  assign ext_int_req = ext_hit;

  // sticky status, cleared by a read; an event in the clearing cycle survives
  wire [15:0] stat_events = {edge_hit, 2'b00, ext_hit};
  wire        stat_clr    = rd_cap & (a_ff.idx == ppf_pkg::IDX_IRQ_STAT);
  assign nxt_irq_stat = (stat_clr ? 16'h0000 : irq_stat_ff) | stat_events;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq_stat_ff <= ppf_pkg::STAT_RST;
    else
      irq_stat_ff <= nxt_irq_stat;
  end

  assign irq = |(irq_stat_ff & irq_mask_ff);

  // read mux
  wire [7:0] port_rd = (d_sel == ppf_pkg::SEL_DATA) ? port_view[d_port] :
                       (d_sel == ppf_pkg::SEL_MODE) ? mode_eff[d_port]  :
                       (d_sel == ppf_pkg::SEL_PULL) ? pull_ff[d_port]   : 8'h00;
  wire [15:0] misc_rd =
    (a_ff.idx == ppf_pkg::IDX_LCD_CTRL) ? {8'h00, lcd_display_control_reg_ff}     :
    (a_ff.idx == ppf_pkg::IDX_CLK_CTRL) ? {8'h00, processor_clock_control_reg_ff} :
    (a_ff.idx == ppf_pkg::IDX_RISE_SEL) ? {8'h00, rise_sel_ff}                    :
    (a_ff.idx == ppf_pkg::IDX_FALL_SEL) ? {8'h00, fall_sel_ff}                    :
    (a_ff.idx == ppf_pkg::IDX_IRQ_STAT) ? irq_stat_ff                             :
    (a_ff.idx == ppf_pkg::IDX_IRQ_MASK) ? irq_mask_ff                             :
    (a_ff.idx == ppf_pkg::IDX_ALT_SEL)  ? {8'h00, alt_sel_ff}                     :
                                          {8'h00, adc_sel_ff};
  assign rdata = d_is_port ? {24'h00_0000, port_rd} : {16'h0000, misc_rd};

  // checks
  a_dir_indep: assert property (@(posedge hclk) disable iff (!hresetn)
    pins[ppf_pkg::PORT_EDGE].oe == ~mode_ff[ppf_pkg::PORT_EDGE])
    else $error("edge port direction does not follow its mode bits");

  a_pull_input: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(pull_ff[ppf_pkg::PORT_EDGE][0]) && mode_ff[ppf_pkg::PORT_EDGE][0]
      |-> pins[ppf_pkg::PORT_EDGE].pu[0])
    else $error("pull-up not applied to an input pin");

  a_pull_output: assert property (@(posedge hclk) disable iff (!hresetn)
    (pins[ppf_pkg::PORT_TIMER].pu & ~mode_ff[ppf_pkg::PORT_TIMER]) == 8'h00 &&
    (pins[ppf_pkg::PORT_EDGE].pu & ~mode_ff[ppf_pkg::PORT_EDGE]) == 8'h00)
    else $error("pull-up on an output pin");

  a_seg_pair: assert property (@(posedge hclk) disable iff (!hresetn)
    lcd_display_control_reg_ff[0] |->
      pins[ppf_pkg::PORT_SEG_A].oe[1:0] == 2'b11 &&
      pins[ppf_pkg::PORT_SEG_A].dout[1:0] == shared_segment_outputs[1:0])
    else $error("segment pair not routed to port a pins");

  a_seg_pair_b: assert property (@(posedge hclk) disable iff (!hresetn)
    lcd_display_control_reg_ff[5] |->
      pins[ppf_pkg::PORT_SEG_B].oe[3:2] == 2'b11 &&
      pins[ppf_pkg::PORT_SEG_B].dout[3:2] == shared_segment_outputs[11:10])
    else $error("segment pair not routed to port b pins");

  a_fall_flag: assert property (@(posedge hclk) disable iff (!hresetn)
    $fell(level[ppf_pkg::PORT_EDGE][3]) |=> irq_stat_ff[ppf_pkg::STAT_EDGE_LSB + 3])
    else $error("falling edge on edge port not flagged");

  a_rise_select: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(level[ppf_pkg::PORT_GEN][2]) |-> (ext_int_req[2] == rise_sel_ff[2]))
    else $error("rising edge request does not match edge select");

  a_fall_select: assert property (@(posedge hclk) disable iff (!hresetn)
    $fell(level[ppf_pkg::PORT_GEN][2]) && fall_sel_ff[2] |-> ext_int_req[2] ##1 irq_stat_ff[2])
    else $error("falling edge request lost");

  a_adc_pullup: assert property (@(posedge hclk) disable iff (!hresetn)
    adc_sel_ff[3] |-> !pins[ppf_pkg::PORT_ANALOG].pu[3])
    else $error("pull-up left on an analog input");

  a_timer_out: assert property (@(posedge hclk) disable iff (!hresetn)
    alt_sel_ff[ppf_pkg::ALT_TIMER_BIT] |->
      pins[ppf_pkg::PORT_TIMER].oe[0] && pins[ppf_pkg::PORT_TIMER].dout[0] == wide_timer_out)
    else $error("timer output not on first timer pin");

  a_timer_off: assert property (@(posedge hclk) disable iff (!hresetn)
    !alt_sel_ff[ppf_pkg::ALT_TIMER_BIT] && mode_ff[ppf_pkg::PORT_TIMER][0]
      |-> !pins[ppf_pkg::PORT_TIMER].oe[0])
    else $error("first timer pin drives while released to input");

  a_reset_inputs: assert property (@(posedge hclk) disable iff (!hresetn)
    !$past(hresetn) |-> pins[ppf_pkg::PORT_SEG_B].oe == 8'h00 && pins[ppf_pkg::PORT_EDGE].pu == 8'h00)
    else $error("pin driving or pulled right after reset");

  a_read_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    stat_clr && stat_events == 16'h0000 |=> irq_stat_ff == 16'h0000 && hreadyout)
    else $error("status not cleared by its read");

endmodule : ppf_port_ctrl

// ===== ppf_board.sv
// board circuitry on the port pins: external drivers, pull-up level and floating pins
// assumes pins of the block drive when oe is high; a driven pin wins over the board
`timescale 1ns/1ps
module ppf_board
(
  input  wire logic                                   hclk,
  input  wire ppf_pkg::ppf_pin_group_type [ppf_pkg::NPORT-1:0] pins,
  input  wire logic [ppf_pkg::NPORT-1:0][7:0]         ext_val,
  input  wire logic [ppf_pkg::NPORT-1:0][7:0]         ext_en,
  output logic      [ppf_pkg::NPORT-1:0][7:0]         pin_in
);
  logic tog_ff = 1'b0;

  // an undriven pin without pull-up wanders every cycle
  always @(posedge hclk)
    tog_ff <= ~tog_ff;

  always_comb
  begin
    for (int p = 0; p < ppf_pkg::NPORT; p++)
    begin
      for (int b = 0; b < 8; b++)
      begin
        if (pins[p].oe[b] === 1'b1)
          pin_in[p][b] = pins[p].dout[b];
        else if (ext_en[p][b])
          pin_in[p][b] = ext_val[p][b];
        else if (pins[p].pu[b] === 1'b1)
          pin_in[p][b] = 1'b1;
        else
          pin_in[p][b] = tog_ff ^ b[0];
      end
    end
  end
endmodule : ppf_board

// ===== ppf_port_ctrl_tb_top.sv
// self-checking bench for the port pin function block, one task per scenario except the feedback resistor cut check, which runs inline
// assumes the block answers on AHB-Lite with hready tied to its own hreadyout
`timescale 1ns/1ps
module ppf_port_ctrl_tb_top;
  `define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_count++; $display("ERROR t=%0t got=%0h exp=%0h", $time, g, e); end end
  logic                                    hclk = 1'b0;
  logic                                    hresetn = 1'b0;
  logic                                    hsel = 1'b0;
  logic [31:0]                             haddr = 32'h0;
  logic [1:0]                              htrans = 2'h0;
  logic                                    hwrite = 1'b0;
  logic [2:0]                              hsize = 3'h2;
  logic [31:0]                             hwdata = 32'h0;
  logic [31:0]                             hrdata;
  logic                                    hreadyout;
  logic                                    hresp;
  logic [ppf_pkg::NPORT-1:0][7:0]          pin_in;
  ppf_pkg::ppf_pin_group_type [ppf_pkg::NPORT-1:0] pins;
  logic [15:0]                             seg = 16'h0;
  logic                                    timer = 1'b0;
  logic [7:0]                              conv;
  logic                                    fbc;
  logic [5:0]                              ext_int_req;
  logic                                    irq;
  logic [ppf_pkg::NPORT-1:0][7:0]          ext_val = '0;
  logic [ppf_pkg::NPORT-1:0][7:0]          ext_en = 48'hff00_0000_00ff;
  logic [31:0]                             rd;
  int                                      err_count = 0;
  int                                      samples_checked = 0;
  int                                      pulse_ff = 0;

  always #50 hclk = ~hclk;

  always @(posedge hclk)
    if (ext_int_req[2] === 1'b1)
      pulse_ff <= pulse_ff + 1;

  ppf_port_ctrl i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pin_in(pin_in), .pins(pins), .shared_segment_outputs(seg),
    .wide_timer_out(timer), .converter_input_sel(conv), .feedback_resistor_cut_bit(fbc),
    .ext_int_req(ext_int_req), .irq(irq));

  ppf_board i_board (.hclk(hclk), .pins(pins), .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));

  task test_done;
    $display("checks=%0d errors=%0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : test_done

  task wait_ready;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
    begin
      n++;
      if (n > 20)
      begin
        err_count++;
        test_done;
      end
      @(posedge hclk);
    end
  endtask : wait_ready

  task xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= ppf_pkg::HTRANS_NONSEQ;
    haddr  <= a;
    hwrite <= w;
    wait_ready;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready;
    r = hrdata;
    `CHK(hresp, ppf_pkg::HRESP_OKAY)
    @(negedge hclk);
  endtask : xfer

  task wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask : wr

  task rdchk(input logic [31:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0, rd);
    `CHK(rd, e)
  endtask : rdchk

  task cyc(input int n);
    repeat (n) @(posedge hclk);
    @(negedge hclk);
  endtask : cyc

  task t_reset;
    for (int p = 0; p < ppf_pkg::NPORT; p++)
    begin
      `CHK({pins[p].oe, pins[p].pu}, 16'h0000)
      rdchk(32'(p * 16 + 4), 32'hff);
      rdchk(32'(p * 16 + 8), 32'h00);
    end
    rdchk(32'h0c, 32'h0);
    `CHK({irq, conv, fbc}, 10'h000)
  endtask : t_reset

  task t_dir;
    wr(32'h34, 32'hfe);
    wr(32'h30, 32'h5b);
    `CHK({pins[3].oe, pins[3].dout[0]}, 9'h003)
    wr(32'h04, 32'h00);
    rdchk(32'h04, 32'hc1);
    `CHK(pins[0].oe, 8'h3e)
    wr(32'h04, 32'hff);
    wr(32'h34, 32'hff);
  endtask : t_dir

  task t_pull;
    wr(32'h58, 32'hff);
    wr(32'h54, 32'hf0);
    `CHK({pins[5].pu, pins[5].oe}, 16'hf00f)
    wr(32'h54, 32'hff);
    wr(32'h58, 32'h00);
  endtask : t_pull

  task t_lcd;
    @(posedge hclk);
    seg <= 16'ha5c3;
    wr(32'h60, 32'h21);
    `CHK({pins[3].oe, pins[3].dout[1:0]}, 10'h00f)
    `CHK({pins[4].oe, pins[4].dout[3:2]}, 10'h031)
    wr(32'h60, 32'hf0);
    `CHK({pins[4].oe, pins[4].dout, pins[3].oe}, 24'hffa500)
    wr(32'h60, 32'h00);
  endtask : t_lcd

  task t_analog;
    wr(32'h18, 32'hff);
    wr(32'h7c, 32'h0f);
    `CHK({pins[1].pu, conv}, 16'hf00f)
    wr(32'h14, 32'hfe);
    `CHK(conv, 8'h0e)
    wr(32'h14, 32'hff);
    wr(32'h7c, 32'h00);
  endtask : t_analog

  task t_timer;
    wr(32'h78, 32'h01);
    for (int v = 0; v < 2; v++)
    begin
      @(posedge hclk);
      timer <= v[0];
      @(negedge hclk);
      `CHK({pins[2].oe[0], pins[2].dout[0]}, {1'b1, v[0]})
    end
    wr(32'h78, 32'h00);
    `CHK(pins[2].oe[0], 1'b0)
  endtask : t_timer

  task t_ext;
    int base;
    logic r;
    logic f;
    wr(32'h74, 32'h0004);
    for (int m = 0; m < 3; m++)
    begin
      r = (m != 1);
      f = (m != 0);
      wr(32'h68, {29'h0, r, 2'h0});
      wr(32'h6c, {29'h0, f, 2'h0});
      xfer(1'b0, 32'h70, 32'h0, rd);
      base = pulse_ff;
      @(posedge hclk);
      ext_val[0][2] <= 1'b1;
      cyc(8);
      `CHK(irq, r)
      rdchk(32'h70, {29'h0, r, 2'h0});
      `CHK(irq, 1'b0)
      @(posedge hclk);
      ext_val[0][2] <= 1'b0;
      cyc(8);
      `CHK(pulse_ff - base, int'(r) + int'(f))
      rdchk(32'h70, {29'h0, f, 2'h0});
    end
  endtask : t_ext

  task t_edge;
    wr(32'h68, 32'h0);
    wr(32'h6c, 32'h0);
    wr(32'h74, 32'h0800);
    xfer(1'b0, 32'h70, 32'h0, rd);
    @(posedge hclk);
    ext_val[5][3] <= 1'b1;
    cyc(8);
    rdchk(32'h70, 32'h0);
    @(posedge hclk);
    ext_val[5][3] <= 1'b0;
    cyc(8);
    `CHK(irq, 1'b1)
    rdchk(32'h70, 32'h0800);
    `CHK(irq, 1'b0)
  endtask : t_edge

  initial
  begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    cyc(1);
    t_reset;
    t_dir;
    t_pull;
    t_lcd;
    t_analog;
    t_timer;
    wr(32'h64, 32'h40);
    `CHK(fbc, 1'b1)
    rdchk(32'h64, 32'h40);
    t_ext;
    t_edge;
    test_done;
  end

  initial
  begin
    repeat (20000) @(posedge hclk);
    err_count++;
    test_done;
  end
endmodule : ppf_port_ctrl_tb_top
